// ===== rtl/fuse_params.svh
/*
 * Constants of the fuse store and its table-read path: fuse field positions,
 * fuse and lock defaults, table layout, read windows and controller offsets.
 * Assumes it is included by bare name wherever these numbers are needed.
 */
`ifndef FUSE_PARAMS_SVH
`define FUSE_PARAMS_SVH

// Extended fuse byte fields
`define EXT_SLEEP_BOD_HI 4
`define EXT_SLEEP_BOD_LO 3
`define EXT_ACTIVE_BOD_HI 2
`define EXT_ACTIVE_BOD_LO 1
`define EXT_SELF_PROG 0
`define EXT_UNUSED_MASK 8'hE0
`define EXT_DEFAULT 8'hFF

// High fuse byte fields
`define HIGH_EXT_RESET_DIS 7
`define HIGH_DEBUG_LINK 6
`define HIGH_SERIAL_PROG 5
`define HIGH_WATCHDOG_ON 4
`define HIGH_EEPROM_KEEP 3
`define HIGH_BOD_LEVEL_MSB 2
`define HIGH_DEFAULT 8'hDF

// Low fuse byte fields
`define LOW_CLK_DIV8 7
`define LOW_CLK_TO_PIN 6
`define LOW_STARTUP_SEL 4
`define LOW_CLK_SRC_MSB 3
`define LOW_UNUSED_MASK 8'h20
`define LOW_DEFAULT 8'h62

// Lock byte
`define LOCK_BIT_ONE 0
`define LOCK_DEFAULT 8'hFF

// Pointer codes of the fuse and lock read
`define PTR_LOW_FUSE 2'h0
`define PTR_LOCK 2'h1
`define PTR_EXT_FUSE 2'h2
`define PTR_HIGH_FUSE 2'h3

// Signature and calibration table byte addresses
`define TBL_SIG0 6'h00
`define TBL_FAST_CAL 6'h01
`define TBL_SIG1 6'h02
`define TBL_TEMP_A 6'h03
`define TBL_SIG2 6'h04
`define TBL_TEMP_B 6'h05
`define TBL_SLOW_CAL 6'h07
`define TBL_TS_GAIN 6'h2C
`define TBL_TS_OFFSET 6'h2D
`define TBL_RESERVED 8'hFF

// Program memory control bits
`define CTRL_SIG_READ 5
`define CTRL_FUSE_READ 3
`define CTRL_ENABLE 0
`define CTRL_WRITABLE 8'h3F

// Windows in CPU cycles after the control write
`define LPM_WINDOW 3'h3
`define SPM_WINDOW 3'h4

// Controller register offsets
`define CMD_OFS 8'h00
`define PTR_OFS 8'h04
`define STAT_OFS 8'h08
`define CMD_START 0
`define CMD_SIG_MODE 1
`define CMD_PLAIN 2
`define CMD_DELAY_LSB 4
`define STAT_BUSY 0
`define STAT_DONE 1

`endif

// ===== rtl/fuse_pkg.sv
/*
 * Types of the table-read controller; the fuse store uses none of them.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fuse_pkg;

	// Controller sequence, Gray coded from H_IDLE through H_WAIT to H_DONE
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_CTRL = 3'h1,
		H_WAIT = 3'h3,
		H_LPM = 3'h2,
		H_DONE = 3'h6
	} host_state_t;

endpackage

// ===== rtl/fuse_link_if.sv
/*
 * Link between the CPU core side and the fuse store: control write,
 * table-read and store strobes, pointer, and the returned byte.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface fuse_link_if;
	logic ctrl_we;
	logic [7:0] ctrl_wdata;
	logic [7:0] ctrl_rdata;
	logic lpm_req;
	logic spm_req;
	logic [15:0] ptr;
	logic [7:0] lpm_data;
	logic lpm_valid;

	modport device (
		input ctrl_we, ctrl_wdata, lpm_req, spm_req, ptr,
		output ctrl_rdata, lpm_data, lpm_valid
	);

	modport cpu (
		output ctrl_we, ctrl_wdata, lpm_req, spm_req, ptr,
		input ctrl_rdata, lpm_data, lpm_valid
	);
endinterface

// ===== rtl/sig_table_rom.sv
/*
 * Read-only signature and calibration table, byte and word read ports,
 * plus the two oscillator trim bytes for the reset-time copy.
 * Assumes the instantiating end registers whatever leaves it.
 */
`timescale 1ns/1ps
`include "fuse_params.svh"
module sig_table_rom #(
	parameter logic [7:0] SIG0 = 8'hA5, // Arbitrary identity value
	parameter logic [7:0] SIG1 = 8'h5A, // Arbitrary identity value
	parameter logic [7:0] SIG2 = 8'h3C, // Arbitrary identity value
	parameter logic [7:0] FAST_CAL = 8'h80,
	parameter logic [7:0] TEMP_A = 8'h40,
	parameter logic [7:0] TEMP_B = 8'h40,
	parameter logic [7:0] SLOW_CAL = 8'h80,
	parameter logic [7:0] TS_GAIN = 8'h80,
	parameter logic [7:0] TS_OFFSET = 8'h00
) (
	// Byte port for firmware reads
	input wire logic [5:0] byte_addr,
	output logic [7:0] byte_data,
	// Word port for external programmers
	input wire logic [4:0] word_addr,
	output logic [15:0] word_data,
	// Trim bytes for the reset copy
	output logic [7:0] fast_trim,
	output logic [7:0] slow_trim
);
	logic [7:0] tbl [0:63];

	// Content of one byte location; gain has 7 fractional bits
	function automatic logic [7:0] entry(input logic [5:0] a);
		case (a)
			`TBL_SIG0: entry = SIG0;
			`TBL_SIG1: entry = SIG1;
			`TBL_SIG2: entry = SIG2;
			`TBL_FAST_CAL: entry = FAST_CAL;
			`TBL_TEMP_A: entry = TEMP_A;
			`TBL_TEMP_B: entry = TEMP_B;
			`TBL_SLOW_CAL: entry = SLOW_CAL;
			`TBL_TS_GAIN: entry = TS_GAIN;
			`TBL_TS_OFFSET: entry = TS_OFFSET;
			default: entry = `TBL_RESERVED;
		endcase
	endfunction

	// One constant per location
	for (genvar i = 0; i < 64; i++) begin : g_tbl
		assign tbl[i] = entry(6'(i));
	end

	// Byte reads inside, word pairs (even byte low) outside
	assign byte_data = tbl[byte_addr];
	assign word_data = {tbl[{word_addr, 1'b1}], tbl[{word_addr, 1'b0}]};
	assign fast_trim = tbl[`TBL_FAST_CAL];
	assign slow_trim = tbl[`TBL_SLOW_CAL];
endmodule

// ===== rtl/fuse_store_device.sv
/*
 * Fuse store with firmware table-read path: three fuse bytes and a lock
 * byte, their latched working copies, the reset-time trim copy and the
 * program memory control bits with their read windows.
 * Assumes a CPU end on the device modport in the same clock domain, and a
 * program memory that answers pmem_rdata in the same cycle as pmem_addr.
 */
// Our own choice: register access over APB.
// How it works
// - Programmed fuse reads zero, unprogrammed one
// - Extended byte: sleep, active brown-out, self-program
// - High byte fields; serial programming default programmed
// - Serial path cannot change serial enable
// - Reset/debug fuse blocks serial, parallel may clear
// - Low byte: div8, clock pin, startup, source
// - Defaults select calibrated fast oscillator, longest start
// - Lock bit one programmed freezes all fuses
// - Chip erase leaves fuses untouched
// - Fuses latched on programming mode entry/exit
// - EEPROM preserve acts immediately, never latched
// - Fuses latched at power-up in normal mode
// - Table bytes internally, words externally
// - Signature and trim bytes at fixed addresses
// - Sensor gain and offset bytes, rest reserved
// - Signature readable regardless of lock state
// - Reset copies trim bytes into trim registers
// - Fuse/lock read within three cycles returns byte
// - Control bits clear on read or timeout
// - Bits clear: table read reads program memory
// - Pointer one returns lock byte
// - Pointers zero, three, two: low, high, extended
// - Signature read within three cycles returns byte
// - Pointer code one alone picks lock over fuse
`timescale 1ns/1ps
`include "fuse_params.svh"
module fuse_store_device (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Link to the CPU core
	fuse_link_if.device link,
	// Programming port
	input wire logic prog_mode,
	input wire logic prog_serial,
	input wire logic prog_fuse_we,
	input wire logic [1:0] prog_fuse_sel,
	input wire logic [7:0] prog_wdata,
	input wire logic prog_lock_we,
	input wire logic prog_chip_erase,
	input wire logic [4:0] prog_word_addr,
	output logic [15:0] prog_table_word,
	output logic [7:0] prog_fuse_rdata,
	// Program memory
	output logic [15:0] pmem_addr,
	input wire logic [7:0] pmem_rdata,
	// Working configuration
	output logic [7:0] active_ext,
	output logic [7:0] active_high,
	output logic [7:0] active_low,
	output logic eeprom_preserve,
	output logic reset_pin_repurposed,
	output logic serial_prog_blocked,
	output logic [7:0] fast_osc_trim,
	output logic [7:0] slow_osc_trim
);
	logic [7:0] fuse_ext_q;
	logic [7:0] fuse_high_q;
	logic [7:0] fuse_low_q;
	logic [7:0] lock_q;
	logic boot_q;
	logic prog_mode_q;
	logic [7:0] ctrl_q;
	logic [2:0] win_q;
	logic lpm_valid_q;
	logic [7:0] lpm_data_q;
	logic pmem_pend_q;
	logic [15:0] pmem_addr_q;
	logic [15:0] prog_table_word_q;
	logic [7:0] prog_fuse_rdata_q;
	logic [7:0] active_ext_q;
	logic [7:0] active_high_q;
	logic [7:0] active_low_q;
	logic eeprom_preserve_q;
	logic reset_pin_repurposed_q;
	logic serial_prog_blocked_q;
	logic [7:0] fast_osc_trim_q;
	logic [7:0] slow_osc_trim_q;
	logic [7:0] tbl_byte;
	logic [15:0] tbl_word;
	logic [7:0] rom_fast;
	logic [7:0] rom_slow;

	// Stored byte chosen by a pointer code; stored values are raw fuse levels
	function automatic logic [7:0] fuse_pick(input logic [1:0] sel, input logic [7:0] lo,
		input logic [7:0] lk, input logic [7:0] ex, input logic [7:0] hi);
		case (sel)
			`PTR_LOW_FUSE: fuse_pick = lo;
			`PTR_LOCK: fuse_pick = lk;
			`PTR_EXT_FUSE: fuse_pick = ex;
			default: fuse_pick = hi;
		endcase
	endfunction

	sig_table_rom u_rom (
		.byte_addr(link.ptr[5:0]),
		.byte_data(tbl_byte),
		.word_addr(prog_word_addr),
		.word_data(tbl_word),
		.fast_trim(rom_fast),
		.slow_trim(rom_slow)
	);

	// Programming permission; serial path needs its enable and no pin takeover
	wire fuses_locked = ~lock_q[`LOCK_BIT_ONE];
	wire serial_ok = ~active_high_q[`HIGH_SERIAL_PROG] & active_high_q[`HIGH_EXT_RESET_DIS]
		& active_high_q[`HIGH_DEBUG_LINK];
	wire prog_ok = prog_mode & (~prog_serial | serial_ok);
	wire fuse_wr = prog_ok & prog_fuse_we & ~fuses_locked;
	wire [7:0] ext_wdata = prog_wdata | `EXT_UNUSED_MASK;
	wire [7:0] low_wdata = prog_wdata | `LOW_UNUSED_MASK;
	wire [7:0] high_wdata = prog_serial ?
		{prog_wdata[7:6], fuse_high_q[`HIGH_SERIAL_PROG], prog_wdata[4:0]} : prog_wdata;

	// Nonvolatile fuse bytes; programmed bits are stored as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuse_ext_q <= `EXT_DEFAULT;
			fuse_high_q <= `HIGH_DEFAULT;
			fuse_low_q <= `LOW_DEFAULT;
		end else if (ce && fuse_wr) begin
			case (prog_fuse_sel)
				`PTR_LOW_FUSE: fuse_low_q <= low_wdata;
				`PTR_EXT_FUSE: fuse_ext_q <= ext_wdata;
				`PTR_HIGH_FUSE: fuse_high_q <= high_wdata;
				default: fuse_low_q <= fuse_low_q;
			endcase
		end
	end

	// Lock byte only tightens; chip erase reopens it and spares the fuses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q <= `LOCK_DEFAULT;
		end else if (ce) begin
			if (prog_mode && prog_chip_erase) begin
				lock_q <= `LOCK_DEFAULT;
			end else if (prog_ok && prog_lock_we) begin
				lock_q <= lock_q & prog_wdata;
			end
		end
	end

	// Working copy taken at first cycle after reset and on any mode change
	wire latch_now = ~boot_q | (prog_mode != prog_mode_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_q <= 1'b0;
			prog_mode_q <= 1'b0;
			active_ext_q <= `EXT_DEFAULT;
			active_high_q <= `HIGH_DEFAULT;
			active_low_q <= `LOW_DEFAULT;
		end else if (ce) begin
			boot_q <= 1'b1;
			prog_mode_q <= prog_mode;
			if (latch_now) begin
				active_ext_q <= fuse_ext_q;
				active_high_q <= fuse_high_q;
				active_low_q <= fuse_low_q;
			end
		end
	end

	// Status flags; EEPROM preserve follows the stored bit, not the copy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eeprom_preserve_q <= 1'b0;
			reset_pin_repurposed_q <= 1'b0;
			serial_prog_blocked_q <= 1'b0;
		end else if (ce) begin
			eeprom_preserve_q <= ~fuse_high_q[`HIGH_EEPROM_KEEP];
			reset_pin_repurposed_q <= ~active_high_q[`HIGH_EXT_RESET_DIS]
				| ~active_high_q[`HIGH_DEBUG_LINK];
			serial_prog_blocked_q <= ~serial_ok;
		end
	end

	// Trim copy in the first cycle after reset; reset itself loads a constant
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_osc_trim_q <= 8'h00;
			slow_osc_trim_q <= 8'h00;
		end else if (ce && !boot_q) begin
			fast_osc_trim_q <= rom_fast;
			slow_osc_trim_q <= rom_slow;
		end
	end

	// Programmer read port ignores the lock byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_table_word_q <= 16'h0000;
			prog_fuse_rdata_q <= 8'hFF;
		end else if (ce) begin
			prog_table_word_q <= tbl_word;
			prog_fuse_rdata_q <= fuse_pick(prog_fuse_sel, fuse_low_q, lock_q,
				fuse_ext_q, fuse_high_q);
		end
	end

	// Window decode; read modes close after three cycles, plain enable after four
	wire enabled = ctrl_q[`CTRL_ENABLE];
	wire read_mode = enabled & (ctrl_q[`CTRL_FUSE_READ] | ctrl_q[`CTRL_SIG_READ]);
	wire [2:0] last_cycle = read_mode ? (`LPM_WINDOW - 3'h1) : (`SPM_WINDOW - 3'h1);
	wire lpm_special = link.lpm_req & read_mode;
	wire clear_now = lpm_special | link.spm_req | (enabled & (win_q == last_cycle));
	wire [7:0] fuse_byte = fuse_pick(link.ptr[1:0], fuse_low_q, lock_q,
		fuse_ext_q, fuse_high_q);

	// Control bits; a new write wins over the self-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 8'h00;
			win_q <= 3'h0;
		end else if (ce) begin
			if (link.ctrl_we) begin
				ctrl_q <= link.ctrl_wdata & `CTRL_WRITABLE;
				win_q <= 3'h0;
			end else if (clear_now) begin
				ctrl_q <= 8'h00;
				win_q <= 3'h0;
			end else if (enabled) begin
				win_q <= win_q + 3'h1;
			end
		end
	end

	// Table-read answer; plain reads take one extra cycle through memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpm_valid_q <= 1'b0;
			lpm_data_q <= 8'h00;
			pmem_pend_q <= 1'b0;
			pmem_addr_q <= 16'h0000;
		end else if (ce) begin
			lpm_valid_q <= 1'b0;
			if (lpm_special) begin
				lpm_data_q <= ctrl_q[`CTRL_SIG_READ] ? tbl_byte : fuse_byte;
				lpm_valid_q <= 1'b1;
			end else if (link.lpm_req) begin
				pmem_addr_q <= link.ptr;
				pmem_pend_q <= 1'b1;
			end else if (pmem_pend_q) begin
				lpm_data_q <= pmem_rdata;
				lpm_valid_q <= 1'b1;
				pmem_pend_q <= 1'b0;
			end
		end
	end

	// Outputs, all from flip-flops
	assign link.ctrl_rdata = ctrl_q;
	assign link.lpm_data = lpm_data_q;
	assign link.lpm_valid = lpm_valid_q;
	assign pmem_addr = pmem_addr_q;
	assign prog_table_word = prog_table_word_q;
	assign prog_fuse_rdata = prog_fuse_rdata_q;
	assign active_ext = active_ext_q;
	assign active_high = active_high_q;
	assign active_low = active_low_q;
	assign eeprom_preserve = eeprom_preserve_q;
	assign reset_pin_repurposed = reset_pin_repurposed_q;
	assign serial_prog_blocked = serial_prog_blocked_q;
	assign fast_osc_trim = fast_osc_trim_q;
	assign slow_osc_trim = slow_osc_trim_q;
endmodule

// ===== rtl/cpu_table_reader.sv
/*
 * CPU core end of the fuse link: an APB slave takes a read order, then
 * writes the control bits, waits a chosen gap and issues the table read.
 * Assumes the device end on the cpu modport in the same clock domain.
 */
`timescale 1ns/1ps
`include "fuse_params.svh"
module cpu_table_reader (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to the fuse store
	fuse_link_if.cpu link
);
	fuse_pkg::host_state_t state_q;
	logic [7:0] cmd_q;
	logic [15:0] ptr_q;
	logic [2:0] cnt_q;
	logic done_q;
	logic [7:0] data_q;
	logic ctrl_we_q;
	logic [7:0] ctrl_wdata_q;
	logic lpm_req_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	// Bus decode; one wait state, transfer ends when pready is seen high
	wire access = psel & penable & ~pready_q;
	wire finish = psel & penable & pready_q;
	wire hit_cmd = paddr == `CMD_OFS;
	wire hit_ptr = paddr == `PTR_OFS;
	wire hit_stat = paddr == `STAT_OFS;
	wire mapped = hit_cmd | hit_ptr | hit_stat;
	wire wr_cmd = finish & pwrite & hit_cmd;
	wire busy = state_q != fuse_pkg::H_IDLE;
	wire start = wr_cmd & pwdata[`CMD_START] & ~busy;
	wire clr_done = finish & pwrite & hit_stat & pwdata[`STAT_DONE];
	wire [31:0] stat_word = {16'h0000, data_q, 6'h00, done_q, busy};
	wire [31:0] rd_word = hit_cmd ? {24'h000000, cmd_q} :
		hit_ptr ? {16'h0000, ptr_q} : hit_stat ? stat_word : 32'h00000000;
	// APB answer and register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			cmd_q <= 8'h00;
			ptr_q <= 16'h0000;
		end else if (ce) begin
			pready_q <= access;
			pslverr_q <= access & ~mapped;
			prdata_q <= (access & ~pwrite) ? rd_word : 32'h00000000;
			if (wr_cmd && !busy) begin
				cmd_q <= {pwdata[7:1], 1'b0};
			end
			if (finish && pwrite && hit_ptr && !busy) begin
				ptr_q <= pwdata[15:0];
			end
		end
	end

	// Read sequence; the gap counts cycles between control write and read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= fuse_pkg::H_IDLE;
			cnt_q <= 3'h0;
			done_q <= 1'b0;
			data_q <= 8'h00;
			ctrl_we_q <= 1'b0;
			ctrl_wdata_q <= 8'h00;
			lpm_req_q <= 1'b0;
		end else if (ce) begin
			ctrl_we_q <= 1'b0;
			lpm_req_q <= 1'b0;
			if (clr_done) begin
				done_q <= 1'b0;
			end
			case (state_q)
				fuse_pkg::H_IDLE: begin
					if (start) begin
						cnt_q <= pwdata[`CMD_DELAY_LSB +: 3];
						ctrl_wdata_q <= pwdata[`CMD_SIG_MODE] ?
							8'((1 << `CTRL_SIG_READ) | (1 << `CTRL_ENABLE)) :
							8'((1 << `CTRL_FUSE_READ) | (1 << `CTRL_ENABLE));
						ctrl_we_q <= ~pwdata[`CMD_PLAIN];
						lpm_req_q <= pwdata[`CMD_PLAIN];
						state_q <= pwdata[`CMD_PLAIN] ? fuse_pkg::H_LPM : fuse_pkg::H_CTRL;
					end
				end
				fuse_pkg::H_CTRL, fuse_pkg::H_WAIT: begin
					if (cnt_q == 3'h0) begin
						lpm_req_q <= 1'b1;
						state_q <= fuse_pkg::H_LPM;
					end else begin
						cnt_q <= cnt_q - 3'h1;
						state_q <= fuse_pkg::H_WAIT;
					end
				end
				fuse_pkg::H_LPM: begin
					if (link.lpm_valid) begin
						data_q <= link.lpm_data;
						state_q <= fuse_pkg::H_DONE;
					end
				end
				fuse_pkg::H_DONE: begin
					done_q <= 1'b1;
					state_q <= fuse_pkg::H_IDLE;
				end
				default: state_q <= fuse_pkg::H_IDLE;
			endcase
		end
	end

	// Outputs, all from flip-flops; store strobe is never used by this end
	assign link.ctrl_we = ctrl_we_q;
	assign link.ctrl_wdata = ctrl_wdata_q;
	assign link.lpm_req = lpm_req_q;
	assign link.spm_req = 1'b0;
	assign link.ptr = ptr_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule

// ===== bench/fuse_link_props.sv
/*
 * Checker on the fuse link between the CPU end and the fuse store.
 * Assumes one clock domain and signal names as in the link interface.
 */
`timescale 1ns/1ps
module fuse_link_props #(
	parameter logic [7:0] SIG0 = 8'hA5 // Arbitrary identity value
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic ctrl_we,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic lpm_req,
	input wire logic spm_req,
	input wire logic [15:0] ptr,
	input wire logic [7:0] lpm_data,
	input wire logic lpm_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Special read armed at the moment of the table read
	wire armed = ctrl_rdata[0] && (ctrl_rdata[3] || ctrl_rdata[5]);
	wire fuse_mode = ctrl_rdata[0] && ctrl_rdata[3] && !ctrl_rdata[5];
	wire sig_mode = ctrl_rdata[0] && ctrl_rdata[5];

	// Read bits never outlive their short window
	ctrl_clear_a: assert property ((ctrl_we && ctrl_wdata[0] && (ctrl_wdata[3] || ctrl_wdata[5]))
		|-> ##[1:5] ctrl_rdata == 8'h00) else $error("control bits not cleared");
	special_answer_a: assert property (lpm_req && armed |=> lpm_valid)
		else $error("special read gave no answer");
	plain_answer_a: assert property (lpm_req && !ctrl_rdata[0] |=> !lpm_valid ##1 lpm_valid)
		else $error("plain read timing wrong");
	no_stray_valid_a: assert property (lpm_valid |-> $past(lpm_req) || $past(lpm_req, 2))
		else $error("answer without a read");
	lock_byte_a: assert property (lpm_req && fuse_mode && ptr[1:0] == 2'h1
		|=> lpm_data[7:1] == 7'h7F) else $error("lock byte wrong");
	ext_unused_a: assert property (lpm_req && fuse_mode && ptr[1:0] == 2'h2
		|=> lpm_data[7:5] == 3'h7) else $error("extended unused bits wrong");
	low_unused_a: assert property (lpm_req && fuse_mode && ptr[1:0] == 2'h0
		|=> lpm_data[5] == 1'b1) else $error("low unused bit wrong");
	sig_first_a: assert property (lpm_req && sig_mode && ptr == 16'h0000 |=> lpm_data == SIG0)
		else $error("first signature byte wrong");
	ctrl_reserved_a: assert property (ctrl_rdata[7:6] == 2'h0)
		else $error("reserved control bits set");

	// Main scenarios
	fuse_read_c: cover property (lpm_req && fuse_mode);
	sig_read_c: cover property (lpm_req && sig_mode);
	plain_read_c: cover property (lpm_req && !ctrl_rdata[0]);
endmodule

// ===== bench/fuse_signature_readout_test.sv
/*
 * Bench for both ends of the fuse link: APB orders to the CPU end, the
 * programming port of the store driven directly.
 * Assumes the default table contents and a simple program memory model.
 */
`timescale 1ns/1ps
`include "fuse_params.svh"
module fuse_signature_readout_test;
	typedef struct packed {logic [7:0] cmd; logic [15:0] ptr; logic [7:0] exp;} row_t;
	logic pclk = 0, presetn = 0;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic prog_mode = 0, prog_serial = 0, prog_fuse_we = 0, prog_lock_we = 0, prog_chip_erase = 0;
	logic [1:0] prog_fuse_sel = 2'h0;
	logic [7:0] prog_wdata = 8'h00, prog_fuse_rdata, a_ext, a_high, a_low, t_fast, t_slow, b;
	logic [15:0] pmem_addr, table_word;
	logic keep, repurposed, blocked, e;
	logic [4:0] word_addr = 5'h00;
	logic [31:0] r;
	int n_mismatch = 0, n_tests = 0;
	row_t rows [17] = '{
		'{8'h00, 16'h0000, 8'h62}, '{8'h10, 16'h0001, 8'hFF}, '{8'h20, 16'h0002, 8'hFF},
		'{8'h00, 16'h0003, 8'hDF}, '{8'h02, 16'h0000, 8'hA5}, '{8'h12, 16'h0001, 8'h80},
		'{8'h22, 16'h0002, 8'h5A}, '{8'h02, 16'h0003, 8'h40}, '{8'h02, 16'h0004, 8'h3C},
		'{8'h02, 16'h0005, 8'h40}, '{8'h02, 16'h0006, 8'hFF}, '{8'h02, 16'h0007, 8'h80},
		'{8'h02, 16'h002C, 8'h80}, '{8'h02, 16'h002D, 8'h00}, '{8'h02, 16'h0010, 8'hFF},
		'{8'h30, 16'h0055, 8'h96}, '{8'h04, 16'h1234, 8'hF7}};

	// Program memory answers a fixed pattern of its address
	wire [7:0] pmem_rdata = pmem_addr[7:0] ^ 8'hC3;

	always #25 pclk = ~pclk;

	fuse_link_if u_fuse_link_if ();
	fuse_store_device u_fuse_store_device (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.link(u_fuse_link_if), .prog_mode(prog_mode), .prog_serial(prog_serial),
		.prog_fuse_we(prog_fuse_we), .prog_fuse_sel(prog_fuse_sel), .prog_wdata(prog_wdata),
		.prog_lock_we(prog_lock_we), .prog_chip_erase(prog_chip_erase),
		.prog_word_addr(word_addr), .prog_table_word(table_word), .prog_fuse_rdata(prog_fuse_rdata),
		.pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata), .active_ext(a_ext),
		.active_high(a_high), .active_low(a_low), .eeprom_preserve(keep),
		.reset_pin_repurposed(repurposed), .serial_prog_blocked(blocked),
		.fast_osc_trim(t_fast), .slow_osc_trim(t_slow));
	cpu_table_reader u_cpu_table_reader (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_fuse_link_if));
	fuse_link_props u_fuse_link_props (.pclk(pclk), .presetn(presetn),
		.ctrl_we(u_fuse_link_if.ctrl_we), .ctrl_wdata(u_fuse_link_if.ctrl_wdata),
		.ctrl_rdata(u_fuse_link_if.ctrl_rdata), .lpm_req(u_fuse_link_if.lpm_req),
		.spm_req(u_fuse_link_if.spm_req), .ptr(u_fuse_link_if.ptr),
		.lpm_data(u_fuse_link_if.lpm_data), .lpm_valid(u_fuse_link_if.lpm_valid));

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task give_verdict;
		if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer, held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Order one read and wait for its sticky done flag
	task do_read(input logic [7:0] cmd, input logic [15:0] p);
		apb(1, `PTR_OFS, {16'h0, p});
		apb(1, `CMD_OFS, {24'h0, cmd | 8'h01});
		do begin
			apb(0, `STAT_OFS, 32'h0);
		end while (r[`STAT_DONE] !== 1'b1);
		b = r[15:8];
		apb(1, `STAT_OFS, 32'h2);
	endtask

	// Drive the programming port for one cycle
	task prog(input logic fw, input logic lw, input logic ce_, input logic [1:0] s,
		input logic [7:0] d);
		@(posedge pclk);
		prog_fuse_we <= fw;
		prog_lock_we <= lw;
		prog_chip_erase <= ce_;
		prog_fuse_sel <= s;
		prog_wdata <= d;
		@(posedge pclk);
		prog_fuse_we <= 0;
		prog_lock_we <= 0;
		prog_chip_erase <= 0;
		repeat (2) @(posedge pclk);
	endtask

	// Long enough for every order plus margin
	initial begin
		#2000000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		check("active fuses", {a_ext, a_high, a_low}, 24'hFFDF62);
		check("trims", {t_fast, t_slow}, 16'h8080);
		check("flags", {keep, repurposed, blocked}, 3'b000);
		check("table word", table_word, 16'h80A5);
		foreach (rows[i]) begin
			do_read(rows[i].cmd, rows[i].ptr);
			check("read byte", b, rows[i].exp);
		end
		apb(0, 8'h0C, 32'h0);
		check("unmapped error", e, 1'b1);
		check("unmapped data", r, 32'h00000000);
		// Word port pairs bytes 3 and 2, odd byte high
		word_addr <= 5'h01;
		repeat (2) @(posedge pclk);
		check("table word 1", table_word, 16'h405A);
		// Fuse changes wait for the mode change, except EEPROM preserve
		prog_mode <= 1;
		prog(1, 0, 0, 2'h3, 8'hD7);
		check("preserve early", {keep, a_high}, {1'b1, 8'hDF});
		prog_serial <= 1;
		prog(1, 0, 0, 2'h3, 8'hFF);
		check("serial high", prog_fuse_rdata, 8'hDF);
		prog_serial <= 0;
		prog(0, 1, 0, 2'h1, 8'hFE);
		prog(1, 0, 0, 2'h0, 8'h00);
		check("locked low", prog_fuse_rdata, 8'h62);
		prog(0, 0, 1, 2'h1, 8'h00);
		check("erased lock", prog_fuse_rdata, 8'hFF);
		prog(0, 0, 0, 2'h0, 8'h00);
		check("erase keeps low", prog_fuse_rdata, 8'h62);
		prog(1, 0, 0, 2'h3, 8'h5F);
		prog_mode <= 0;
		repeat (3) @(posedge pclk);
		check("latched high", {a_high, repurposed, blocked}, {8'h5F, 2'b11});
		// Reset in mid-run; stored fuses model the default power-up state
		presetn <= 0;
		repeat (2) @(posedge pclk);
		check("trims in reset", {t_fast, t_slow}, 16'h0000);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		check("trims again", {t_fast, t_slow}, 16'h8080);
		check("high again", {a_high, repurposed}, {8'hDF, 1'b0});
		give_verdict();
	end
endmodule
